// ---- core/dssr_top.sv ----
// Top of the dual static recirculating shift register.
`timescale 1ns/1ns
module dssr_top
  import dssr_pkg::*;
#(
  parameter int LEN = DSSR_LEN_LONG,
  parameter int HIGH_MAX_CYC = DSSR_HIGH_MAX_CYC
) (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic shift_clk_in,
  input wire logic sel_in,
  input wire logic serial_in_first,
  input wire logic serial_in_second,
  output logic serial_out_first,
  output logic serial_out_second,
  output logic high_overrun_out
);
  logic [2:0] clk_sync;
  logic [2:0] sel_sync;
  logic [2:0] d0_sync;
  logic [2:0] d1_sync;
  logic clk_level;
  logic shift_edge;
  logic sel_hold;
  logic d0_hold;
  logic d1_hold;
  logic [DSSR_HIGH_CNT_W-1:0] high_cnt;
  logic [DSSR_HIGH_CNT_W-1:0] cnt_limit;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // A pin level counts only once the second and third stages agree on it.
  function automatic logic pin_settled(input logic [2:0] stages);
    pin_settled = (stages[1] == stages[2]);
  endfunction

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  // The shift clock, select and data pins are asynchronous to the system clock, so each one passes three stages.
  always_ff @(posedge sys_clk_in) begin
    clk_sync <= {clk_sync[1:0], shift_clk_in};
  end

  always_ff @(posedge sys_clk_in) begin
    sel_sync <= {sel_sync[1:0], sel_in};
  end

  always_ff @(posedge sys_clk_in) begin
    d0_sync <= {d0_sync[1:0], serial_in_first};
  end

  always_ff @(posedge sys_clk_in) begin
    d1_sync <= {d1_sync[1:0], serial_in_second};
  end

  // ----------------------------------------
  // Shift clock level
  // ----------------------------------------
  // A phase shorter than two system clocks may be lost, so the far side keeps them wider.
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      clk_level <= 1'h0;
    end else if (pin_settled(clk_sync)) begin
      clk_level <= clk_sync[2];
    end
  end

  // The level resets low like an idle pin, so no false shift follows reset.
  // falling edge detect.
  assign shift_edge = clk_level && pin_settled(clk_sync) && !clk_sync[2];

  // ----------------------------------------
  // Master stage
  // ----------------------------------------
  // The lanes take the last settled value seen while high, as a dynamic master would.
  // select tracks while high.
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      sel_hold <= 1'h0;
    end else if (clk_level && pin_settled(sel_sync)) begin
      sel_hold <= sel_sync[2];
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      d0_hold <= 1'h0;
    end else if (clk_level && pin_settled(d0_sync)) begin
      d0_hold <= d0_sync[2];
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      d1_hold <= 1'h0;
    end else if (clk_level && pin_settled(d1_sync)) begin
      d1_hold <= d1_sync[2];
    end
  end

  // ----------------------------------------
  // High phase watchdog
  // ----------------------------------------
  // The limit is cut to the counter width once; a limit beyond its range would wrap.
  assign cnt_limit = DSSR_HIGH_CNT_W'(HIGH_MAX_CYC);

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in || !clk_level) begin
      high_cnt <= '0;
    end else if (high_cnt < cnt_limit) begin
      high_cnt <= high_cnt + 1'h1;
    end
  end

  // The flag stays up for the rest of the high phase, so slow logic still sees it.
  // flag long high phase.
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in || !clk_level) begin
      high_overrun_out <= 1'h0;
    end else if (high_cnt == cnt_limit) begin
      high_overrun_out <= 1'h1;
    end
  end

  // ----------------------------------------
  // Lanes
  // ----------------------------------------
  // Stored bits have no reset, matching a part that powers up with random contents.
  // two lanes, one pulse.
  dssr_lane #(.LEN(LEN)) u_lane_first (
    .sys_clk_in(sys_clk_in),
    .shift_in(shift_edge),
    .sel_in(sel_hold),
    .data_in(d0_hold),
    .data_out(serial_out_first)
  );

  dssr_lane #(.LEN(LEN)) u_lane_second (
    .sys_clk_in(sys_clk_in),
    .shift_in(shift_edge),
    .sel_in(sel_hold),
    .data_in(d1_hold),
    .data_out(serial_out_second)
  );

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  edge_needs_high_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    shift_edge |-> $past(clk_level)) else $error("Shift without prior high level.");
  level_fall_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    $fell(clk_level) |-> $past(shift_edge)) else $error("Clock fell without a shift.");
  edge_single_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    shift_edge |=> !shift_edge) else $error("Two shifts in a row.");
  hold_when_low_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    !shift_edge |=> serial_out_first === $past(serial_out_first) &&
    serial_out_second === $past(serial_out_second))
    else $error("Output moved without a shift.");

  // ----------------------------------------
  // Master and watchdog checks
  // ----------------------------------------
  master_frozen_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    !clk_level |=> $stable(d0_hold) && $stable(d1_hold) && $stable(sel_hold))
    else $error("Master changed while low.");
  master_tracks_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    clk_level && d0_sync[1] == d0_sync[2] |=> d0_hold == $past(d0_sync[2]))
    else $error("Master missed a settled bit.");
  overrun_flag_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    high_overrun_out |-> $past(clk_level)) else $error("Overrun flag without high clock.");
  overrun_late_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    $rose(high_overrun_out) |-> $past(high_cnt) == cnt_limit)
    else $error("Overrun flag raised early.");
  overrun_clear_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    !clk_level |=> !high_overrun_out && high_cnt == '0)
    else $error("Watchdog not cleared while low.");

  // ----------------------------------------
  // Lane checks
  // ----------------------------------------
  // Case equality keeps cells that were never written, and start unknown, from tripping the recirculation and output checks.
  recirc_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    shift_edge && sel_hold == DSSR_SEL_RECIRC |=>
    u_lane_first.cells[0] === $past(serial_out_first)) else $error("Recirculation lost.");
  recirc_second_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    shift_edge && sel_hold == DSSR_SEL_RECIRC |=>
    u_lane_second.cells[0] === $past(serial_out_second)) else $error("Recirculation lost.");
  write_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    shift_edge && sel_hold == DSSR_SEL_WRITE |=>
    u_lane_second.cells[0] == $past(d1_hold)) else $error("Write bit lost.");
  write_first_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    shift_edge && sel_hold == DSSR_SEL_WRITE |=>
    u_lane_first.cells[0] == $past(d0_hold)) else $error("Write bit lost.");
  out_last_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    shift_edge |=> serial_out_first === $past(u_lane_first.cells[LEN-2]))
    else $error("Output not last stage.");
  out_second_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    shift_edge |=> serial_out_second === $past(u_lane_second.cells[LEN-2]))
    else $error("Output not last stage.");

  // ----------------------------------------
  // Coverage
  // ----------------------------------------
  // A long pause, a select change and an overrun are the cases most easily skipped.
  write_cov: cover property (@(posedge sys_clk_in) shift_edge && sel_hold);
  recirc_cov: cover property (@(posedge sys_clk_in) shift_edge && !sel_hold);
  overrun_cov: cover property (@(posedge sys_clk_in) high_overrun_out);
  pause_cov: cover property (@(posedge sys_clk_in) shift_edge ##1 !clk_level [*8]);
  sel_change_cov: cover property (@(posedge sys_clk_in) $changed(sel_hold));
endmodule

// ---- core/dssr_pkg.sv ----
// Package of constants for the dual static recirculating shift register.
package dssr_pkg;
  // ----------------------------------------
  // Register lengths
  // ----------------------------------------
  localparam int DSSR_LEN_LONG = 512;
  localparam int DSSR_LEN_SHORT = 480;
  // ----------------------------------------
  // Select encodings
  // ----------------------------------------
  localparam logic DSSR_SEL_RECIRC = 1'h0;
  localparam logic DSSR_SEL_WRITE = 1'h1;
  // ----------------------------------------
  // Shift clock high phase limit
  // ----------------------------------------
  localparam int DSSR_CLK_PERIOD_NS = 100;
  localparam int DSSR_HIGH_MAX_US = 100;
  localparam int DSSR_HIGH_MAX_CYC = (DSSR_HIGH_MAX_US * 1000) / DSSR_CLK_PERIOD_NS;
  localparam int DSSR_HIGH_CNT_W = 11;
endpackage

// ---- core/dssr_lane.sv ----
// One recirculating static shift register lane.
`timescale 1ns/1ns
module dssr_lane
  import dssr_pkg::*;
#(
  parameter int LEN = DSSR_LEN_LONG
) (
  input wire logic sys_clk_in,
  input wire logic shift_in,
  input wire logic sel_in,
  input wire logic data_in,
  output logic data_out
);
  logic [LEN-1:0] cells;
  logic master;

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  // input choice.
  assign master = (sel_in == DSSR_SEL_WRITE) ? data_in : cells[LEN-1];

  always_ff @(posedge sys_clk_in) begin
    if (shift_in) begin
      cells <= {cells[LEN-2:0], master};
    end
  end

  assign data_out = cells[LEN-1];
endmodule

// ---- testbench/dssr_far_side.sv ----
// Far-side logic model driving shift clock, select and serial data.
`timescale 1ns/1ns
module dssr_far_side (
  input wire logic sys_clk_in,
  output logic shift_clk_out,
  output logic sel_out,
  output logic d1_out,
  output logic d2_out
);
  initial begin
    {shift_clk_out, sel_out, d1_out, d2_out} = 4'h0;
  end
  // ----------------------------------------
  // One shift cycle
  // ----------------------------------------
  // bounded high phase.
  // Data is inverted after the hold so a stale value can never pass for a good one.
  task automatic pulse(input logic s, input logic a, input logic b, input int hi, input int lo);
    @(posedge sys_clk_in);
    #1 {sel_out, d1_out, d2_out} = {s, a, b};
    shift_clk_out = 1'b1;
    repeat (hi) @(posedge sys_clk_in);
    #1 shift_clk_out = 1'b0;
    repeat (lo) @(posedge sys_clk_in);
    #1 {d1_out, d2_out} = ~{a, b};
  endtask
endmodule

// ---- testbench/test_dssr_top.sv ----
// Self-checking bench for the dual static recirculating shift register.
`timescale 1ns/1ns
module test_dssr_top;
  import dssr_pkg::*;
  localparam int L = DSSR_LEN_SHORT;
  localparam int HMAX = 20;
  logic sys_clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic sclk, sel, d1, d2, q1, q2, ovr;
  int failures = 0;
  int n_tests = 0;
  logic m1[$];
  logic m2[$];
  always #50 sys_clk_in = ~sys_clk_in;
  dssr_far_side far (.sys_clk_in(sys_clk_in), .shift_clk_out(sclk), .sel_out(sel),
    .d1_out(d1), .d2_out(d2));
  dssr_top #(.LEN(L), .HIGH_MAX_CYC(HMAX)) DUT (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
    .shift_clk_in(sclk), .sel_in(sel), .serial_in_first(d1), .serial_in_second(d2),
    .serial_out_first(q1), .serial_out_second(q2), .high_overrun_out(ovr));
  task automatic complete_run;
    $display("failures %0d n_tests %0d", failures, n_tests);
    if (failures == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic exp, input logic got);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("unexpected %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic check_flag(input string what, input logic exp, input logic got);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("unexpected %s expected %b seen %b", what, exp, got);
    end
  endtask
  // The model lane front is the first stage; unknown cells are skipped.
  task automatic step(input logic s, input int lo);
    logic a, b;
    a = 1'($urandom_range(1));
    b = 1'($urandom_range(1));
    far.pulse(s, a, b, 5, lo);
    m1.push_front(s ? a : m1[L-1]);
    m2.push_front(s ? b : m2[L-1]);
    m1 = m1[0:L-1];
    m2 = m2[0:L-1];
    check_flag("overrun", 1'h0, ovr);
    if (m1[L-1] !== 1'bx) begin
      check("first lane", m1[L-1], q1);
      check("second lane", m2[L-1], q2);
    end
  endtask
  initial begin
    #4000000;
    failures++;
    complete_run();
  end
  initial begin
    void'($urandom(89827));
    repeat (L) begin
      m1.push_back(1'bx);
      m2.push_back(1'bx);
    end
    repeat (5) @(posedge sys_clk_in);
    #1 rst_n_in = 1'b1;
    repeat (L + 8) step(DSSR_SEL_WRITE, 6);
    // long low pause in mid recirculation.
    for (int i = 0; i < L; i++) step(DSSR_SEL_RECIRC, i == 100 ? 300 : 6);
    // Stored bits are not reset, so they must survive a reset in mid-run.
    @(posedge sys_clk_in);
    #1 rst_n_in = 1'h0;
    repeat (5) @(posedge sys_clk_in);
    #1 rst_n_in = 1'h1;
    check("first lane", m1[L-1], q1);
    check("second lane", m2[L-1], q2);
    repeat (64) step(1'($urandom_range(1)), 6);
    fork
      far.pulse(DSSR_SEL_RECIRC, 1'h0, 1'h0, HMAX + 10, 6);
      begin
        repeat (HMAX + 2) @(posedge sys_clk_in);
        #1 check_flag("overrun", 1'h0, ovr);
        repeat (6) @(posedge sys_clk_in);
        #1 check_flag("overrun", 1'h1, ovr);
      end
    join
    check_flag("overrun", 1'h0, ovr);
    complete_run();
  end
endmodule
